// file: verilog/ssr_map.vh
`ifndef SSR_MAP_VH
`define SSR_MAP_VH
`define SSR_CMD_READ 8'h03
`define SSR_CMD_WRITE 8'h02
`define SSR_ENTER_DUAL_LINE_CMD 8'h3B
`define SSR_LEAVE_DUAL_LINE_CMD 8'hFF
`define SSR_READ_MODE_CMD 8'h05
`define SSR_WRITE_MODE_CMD 8'h01
`define SSR_MODE_BYTE 2'h0
`define SSR_MODE_PAGE 2'h2
`define SSR_MODE_SEQ 2'h1
`define SSR_MODE_RSVD 2'h3
`define SSR_MODE_MSB 7
`define SSR_MODE_LSB 6
`define SSR_MODE_RESET 8'h40
`define SSR_MODE_RSVD_ZERO 6'h00
`define SSR_PAGE_MSB 4
`define SSR_ADDR_BITS 16
`define SSR_BYTE_BITS 4'h8
`define SSR_FIFO_DEPTH 4
`define SSR_FIFO_AW 2
`endif

// file: verilog/ssr_spi_slave.v
`include "ssr_map.vh"

module ssr_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = `SSR_FIFO_DEPTH,
    parameter AW = `SSR_FIFO_AW
) (
    input wire clk,
    input wire rst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] buf_reg [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;
    wire [AW:0] depth_w;

    assign depth_w = DEPTH[AW:0];
    assign in_ready = (count_reg != depth_w);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data = buf_reg[rd_ptr_reg];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @(posedge clk) begin
        if (rst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                buf_reg[wr_ptr_reg] <= in_data;
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                    : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                    : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule // ssr_fifo

module ssr_spi_slave #(
    parameter AW = 16,
    parameter FIFO_DEPTH = `SSR_FIFO_DEPTH,
    parameter FIFO_AW = `SSR_FIFO_AW
) (
    input wire clk,
    input wire rst,
    input wire cs_n,
    input wire sck,
    input wire dual_data_line_zero_in,
    output reg dual_data_line_zero_out,
    output reg dual_data_line_zero_oe,
    input wire dual_data_line_one_in,
    output reg dual_data_line_one_out,
    output reg dual_data_line_one_oe,
    input wire mem_hold,
    output reg dual_mode,
    output reg wr_buf_ready,
    output reg wr_overrun
);
    localparam [2:0] ST_STANDBY = 3'h0;
    localparam [2:0] ST_CMD = 3'h1;
    localparam [2:0] ST_ADDR = 3'h2;
    localparam [2:0] ST_RD = 3'h3;
    localparam [2:0] ST_WR = 3'h4;
    localparam [2:0] ST_MRD = 3'h5;
    localparam [2:0] ST_MWR = 3'h6;
    localparam [2:0] ST_IGN = 3'h7;
    localparam FW = `SSR_ADDR_BITS + 8;

    reg [7:0] mem_reg [0:(1<<AW)-1];
    reg [2:0] sck_sync_reg;
    reg [2:0] cs_sync_reg;
    reg [1:0] d0_sync_reg;
    reg [1:0] d1_sync_reg;
    reg [2:0] state_reg;
    reg [7:0] sh_reg;
    reg [3:0] bit_cnt_reg;
    reg [7:0] op_reg;
    reg [15:0] addr_reg;
    reg addr_lo_reg;
    reg [7:0] mode_reg;
    reg dual_reg;
    reg [7:0] out_sh_reg;
    reg [3:0] out_cnt_reg;

    wire sck_rise;
    wire sck_fall;
    wire cs_hi;
    wire cs_fall;
    wire [1:0] mode_w;
    wire [3:0] step;
    wire [7:0] sh_in;
    wire [3:0] cnt_in;
    wire shifting;
    wire byte_done;
    wire [7:0] rd_src;
    wire [7:0] out_cur;
    wire [3:0] out_cnt_in;
    wire push;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [FW-1:0] fifo_out_data;

    function [15:0] next_addr;
        input [15:0] a;
        input [1:0] m;
        begin
            if (m == `SSR_MODE_PAGE) begin
                next_addr = {a[15:`SSR_PAGE_MSB+1], a[`SSR_PAGE_MSB:0] + 1'b1};
            end else begin
                next_addr = a + 16'h0001;
            end
        end
    endfunction

    // pin synchronisers; edges come from second and third stage
    always @(posedge clk) begin
        if (rst) begin
            sck_sync_reg <= 3'h0;
            cs_sync_reg <= 3'h7;
            d0_sync_reg <= 2'h0;
            d1_sync_reg <= 2'h0;
        end else begin
            sck_sync_reg <= {sck_sync_reg[1:0], sck};
            cs_sync_reg <= {cs_sync_reg[1:0], cs_n};
            d0_sync_reg <= {d0_sync_reg[0], dual_data_line_zero_in};
            d1_sync_reg <= {d1_sync_reg[0], dual_data_line_one_in};
        end
    end

    assign sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
    assign sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];
    assign cs_hi = cs_sync_reg[1];
    assign cs_fall = ~cs_sync_reg[1] & cs_sync_reg[2];
    assign mode_w = mode_reg[`SSR_MODE_MSB:`SSR_MODE_LSB];
    assign step = {2'h0, dual_reg, ~dual_reg};
    // msb first; in dual mode line one carries the higher bit of each pair
    assign sh_in = dual_reg ? {sh_reg[5:0], d1_sync_reg[1], d0_sync_reg[1]}
        : {sh_reg[6:0], d0_sync_reg[1]};
    assign cnt_in = bit_cnt_reg + step;
    assign shifting = (state_reg == ST_CMD) || (state_reg == ST_ADDR) ||
        (state_reg == ST_WR) || (state_reg == ST_MWR);
    assign byte_done = sck_rise && shifting && (cnt_in == `SSR_BYTE_BITS);
    assign rd_src = (state_reg == ST_RD) ? mem_reg[addr_reg[AW-1:0]] : mode_reg;
    assign out_cur = (out_cnt_reg == 4'h0) ? rd_src : out_sh_reg;
    assign out_cnt_in = out_cnt_reg + step;
    assign push = byte_done && (state_reg == ST_WR);

    always @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_STANDBY;
            sh_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
            op_reg <= 8'h00;
            addr_reg <= 16'h0000;
            addr_lo_reg <= 1'b0;
            mode_reg <= `SSR_MODE_RESET;
            dual_reg <= 1'b0;
            out_sh_reg <= 8'h00;
            out_cnt_reg <= 4'h0;
            dual_data_line_zero_out <= 1'b0;
            dual_data_line_zero_oe <= 1'b0;
            dual_data_line_one_out <= 1'b0;
            dual_data_line_one_oe <= 1'b0;
        end else if (cs_hi) begin
            // select high ends any transfer and releases the lines
            state_reg <= ST_STANDBY;
            bit_cnt_reg <= 4'h0;
            out_cnt_reg <= 4'h0;
            dual_data_line_zero_oe <= 1'b0;
            dual_data_line_one_oe <= 1'b0;
        end else if (state_reg == ST_STANDBY) begin
            if (cs_fall) begin
                state_reg <= ST_CMD;
                bit_cnt_reg <= 4'h0;
            end
        end else begin
            if (sck_rise && shifting) begin
                sh_reg <= sh_in;
                bit_cnt_reg <= byte_done ? 4'h0 : cnt_in;
            end
            if (byte_done) begin
                case (state_reg)
                    ST_CMD: begin
                        op_reg <= sh_in;
                        addr_lo_reg <= 1'b0;
                        case (sh_in)
                            `SSR_CMD_READ, `SSR_CMD_WRITE: begin
                                state_reg <= (mode_w == `SSR_MODE_RSVD) ? ST_IGN
                                    : ST_ADDR;
                            end
                            `SSR_READ_MODE_CMD: begin
                                state_reg <= ST_MRD;
                                out_cnt_reg <= 4'h0;
                            end
                            `SSR_WRITE_MODE_CMD: begin
                                state_reg <= ST_MWR;
                            end
                            `SSR_ENTER_DUAL_LINE_CMD: begin
                                dual_reg <= 1'b1;
                                state_reg <= ST_IGN;
                            end
                            `SSR_LEAVE_DUAL_LINE_CMD: begin
                                dual_reg <= 1'b0;
                                state_reg <= ST_IGN;
                            end
                            default: begin
                                state_reg <= ST_IGN;
                            end
                        endcase
                    end
                    ST_ADDR: begin
                        if (!addr_lo_reg) begin
                            addr_reg[15:8] <= sh_in;
                            addr_lo_reg <= 1'b1;
                        end else begin
                            addr_reg[7:0] <= sh_in;
                            out_cnt_reg <= 4'h0;
                            state_reg <= (op_reg == `SSR_CMD_READ) ? ST_RD : ST_WR;
                        end
                    end
                    ST_WR: begin
                        addr_reg <= next_addr(addr_reg, mode_w);
                        if (mode_w == `SSR_MODE_BYTE) begin
                            state_reg <= ST_IGN;
                        end
                    end
                    ST_MWR: begin
                        mode_reg <= {sh_in[7:6], `SSR_MODE_RSVD_ZERO};
                        state_reg <= ST_IGN;
                    end
                    default: begin
                        state_reg <= ST_IGN;
                    end
                endcase
            end
            if (sck_fall && ((state_reg == ST_RD) || (state_reg == ST_MRD))) begin
                // new bits appear only after a falling clock edge
                dual_data_line_one_out <= out_cur[7];
                dual_data_line_one_oe <= 1'b1;
                dual_data_line_zero_out <= out_cur[6];
                dual_data_line_zero_oe <= dual_reg;
                out_sh_reg <= dual_reg ? {out_cur[5:0], 2'h0} : {out_cur[6:0], 1'b0};
                if (out_cnt_in == `SSR_BYTE_BITS) begin
                    out_cnt_reg <= 4'h0;
                    if (state_reg == ST_RD) begin
                        addr_reg <= next_addr(addr_reg, mode_w);
                        if (mode_w == `SSR_MODE_BYTE) begin
                            state_reg <= ST_IGN;
                        end
                    end
                end else begin
                    out_cnt_reg <= out_cnt_in;
                end
            end
            if (sck_fall && (state_reg == ST_IGN)) begin
                dual_data_line_zero_oe <= 1'b0;
                dual_data_line_one_oe <= 1'b0;
            end
        end
    end

    // write bytes queue ahead of the array; while the array port is held, bytes beyond FIFO_DEPTH are dropped and set wr_overrun
    ssr_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_wr_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data({addr_reg, sh_in}),
        .out_valid(fifo_out_valid),
        .out_ready(~mem_hold),
        .out_data(fifo_out_data)
    );

    always @(posedge clk) begin
        if (fifo_out_valid && !mem_hold) begin
            mem_reg[fifo_out_data[AW+7:8]] <= fifo_out_data[7:0];
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            dual_mode <= 1'b0;
            wr_buf_ready <= 1'b0;
            wr_overrun <= 1'b0;
        end else begin
            dual_mode <= dual_reg;
            wr_buf_ready <= fifo_in_ready;
            if (push && !fifo_in_ready) begin
                wr_overrun <= 1'b1;
            end else if (cs_fall) begin
                wr_overrun <= 1'b0;
            end
        end
    end
endmodule // ssr_spi_slave

// file: tb/ssr_spi_slave_asserts.sv
module ssr_spi_slave_asserts (
    input wire clk,
    input wire rst,
    input wire cs_n,
    input wire sck,
    input wire dual_data_line_zero_in,
    input wire dual_data_line_zero_out,
    input wire dual_data_line_zero_oe,
    input wire dual_data_line_one_in,
    input wire dual_data_line_one_out,
    input wire dual_data_line_one_oe,
    input wire mem_hold,
    input wire dual_mode,
    input wire wr_buf_ready,
    input wire wr_overrun
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence deselect_s; $rose(cs_n); endsequence
    sequence lines_free_s; ##[1:6] (!dual_data_line_one_oe && !dual_data_line_zero_oe); endsequence
    AST_OE_RELEASE: assert property (deselect_s |-> lines_free_s)
        else $error("output still driven after deselect");
    AST_IDLE_QUIET: assert property (cs_n [*6] |-> !dual_data_line_one_oe && !dual_data_line_zero_oe)
        else $error("output driven while deselected");
    AST_OUT_ON_FALL: assert property ((dual_data_line_one_oe && $past(dual_data_line_one_oe) && $changed(dual_data_line_one_out))
        |-> !$past(sck, 2))
        else $error("output bit changed outside clock low");
    AST_BIT_HOLD: assert property ((sck && $past(sck) && dual_data_line_one_oe)
        |-> $stable(dual_data_line_one_out) && $stable(dual_data_line_zero_out)) else $error("output bit moved while clock high");
    AST_DUAL_PAIR: assert property (dual_data_line_zero_oe |-> dual_data_line_one_oe && dual_mode)
        else $error("line zero driven outside dual read");
    AST_OVERRUN_CAUSE: assert property ($rose(wr_overrun) |-> !$past(wr_buf_ready))
        else $error("overrun flagged while buffer had room");
    AST_OVERRUN_STICKY: assert property (wr_overrun && cs_n |=> wr_overrun)
        else $error("overrun flag lost while deselected");
    AST_DUAL_IDLE: assert property (cs_n [*4] |-> $stable(dual_mode))
        else $error("dual flag changed while deselected");
endmodule // ssr_spi_slave_asserts

bind ssr_spi_slave ssr_spi_slave_asserts u_ssr_spi_slave_asserts (.clk(clk), .rst(rst),
    .cs_n(cs_n), .sck(sck), .dual_data_line_zero_in(dual_data_line_zero_in), .dual_data_line_zero_out(dual_data_line_zero_out), .dual_data_line_zero_oe(dual_data_line_zero_oe),
    .dual_data_line_one_in(dual_data_line_one_in), .dual_data_line_one_out(dual_data_line_one_out), .dual_data_line_one_oe(dual_data_line_one_oe), .mem_hold(mem_hold),
    .dual_mode(dual_mode), .wr_buf_ready(wr_buf_ready), .wr_overrun(wr_overrun));

// file: tb/ssr_master_model.sv
module ssr_master_model (
    input wire clk,
    input wire line0,
    input wire line1,
    output logic cs_n,
    output logic sck,
    output logic m0,
    output logic m1
);
    timeunit 1ns;
    timeprecision 1ps;
    logic dual;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        m0 = 1'b0;
        m1 = 1'b0;
        dual = 1'b0;
    end
    // one byte at the current width, released lines toggle
    task automatic shift(input logic [7:0] tx, input bit rd, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < (dual ? 4 : 8); i++) begin
            m1 = (rd || !dual) ? ~m1 : tx[7];
            m0 = rd ? ~m0 : (dual ? tx[6] : tx[7]);
            tx = dual ? tx << 2 : tx << 1;
            repeat (4) @(posedge clk);
            #1 sck = 1'b1;
            rx = dual ? {rx[5:0], line1, line0} : {rx[6:0], line1};
            repeat (4) @(posedge clk);
            #1 sck = 1'b0;
        end
    endtask
    // select falls before the command and stays low to the last bit
    task automatic frame(input logic [7:0] tx[$], input int nrx, output logic [7:0] rx[$]);
        logic [7:0] b;
        rx = {};
        cs_n = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        foreach (tx[i]) shift(tx[i], 1'b0, b);
        repeat (nrx) begin
            shift(8'h00, 1'b1, b);
            rx.push_back(b);
        end
        repeat (4) @(posedge clk);
        #1 cs_n = 1'b1;
        if (tx[0] == 8'h3B) dual = 1'b1;
        if (tx[0] == 8'hFF) dual = 1'b0;
        repeat (6) @(posedge clk);
        #1;
    endtask
endmodule // ssr_master_model

// file: tb/ssr_spi_slave_tb_top.sv
module ssr_spi_slave_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, mem_hold, cs_n, sck, m0, m1;
    int oe_cnt = 0;
    wire dual_data_line_zero_out, dual_data_line_zero_oe, dual_data_line_one_out, dual_data_line_one_oe, dual_mode, wr_buf_ready, wr_overrun;
    wire line0 = dual_data_line_zero_oe ? dual_data_line_zero_out : m0;
    wire line1 = dual_data_line_one_oe ? dual_data_line_one_out : m1;
    logic [7:0] mem [int];
    logic [1:0] mode = 2'b01;
    logic [31:0] seed = 32'h66553861;
    int failures = 0;
    int n_compared = 0;
    ssr_spi_slave u_ssr_spi_slave (.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck),
        .dual_data_line_zero_in(line0), .dual_data_line_zero_out(dual_data_line_zero_out), .dual_data_line_zero_oe(dual_data_line_zero_oe), .dual_data_line_one_in(line1),
        .dual_data_line_one_out(dual_data_line_one_out), .dual_data_line_one_oe(dual_data_line_one_oe), .mem_hold(mem_hold), .dual_mode(dual_mode),
        .wr_buf_ready(wr_buf_ready), .wr_overrun(wr_overrun));
    ssr_master_model u_ssr_master_model (.clk(clk), .line0(line0), .line1(line1),
        .cs_n(cs_n), .sck(sck), .m0(m0), .m1(m1));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // counts clocks on which the device drives either line
    always @(posedge clk) if (dual_data_line_one_oe === 1'b1 || dual_data_line_zero_oe === 1'b1) oe_cnt <= oe_cnt + 1;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic int next_a(input int a);
        if (mode == 2'b10) return (a & 32'hFFE0) | ((a + 1) & 32'h1F);
        return (a + 1) & 32'hFFFF;
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input int a, input int n, input bit keep);
        logic [7:0] q[$];
        logic [7:0] r[$];
        int p;
        q = {8'h02, a[15:8], a[7:0]};
        p = a;
        repeat (n) begin
            seed = xs(seed);
            q.push_back(seed[7:0]);
            if (keep && (mode != 2'b00 || p == a)) mem[p] = seed[7:0];
            p = next_a(p);
        end
        u_ssr_master_model.frame(q, 0, r);
    endtask
    task automatic rd(input int a, input int n);
        logic [7:0] q[$];
        logic [7:0] r[$];
        int p;
        q = {8'h03, a[15:8], a[7:0]};
        p = a;
        u_ssr_master_model.frame(q, n, r);
        foreach (r[i]) begin
            chk("read data", mem[p], r[i]);
            p = next_a(p);
        end
    endtask
    task automatic cmd(input logic [7:0] c, input int n, output logic [7:0] r[$]);
        logic [7:0] q[$];
        q = {c};
        u_ssr_master_model.frame(q, n, r);
    endtask
    task automatic read_mode_cmd(input logic [7:0] exp);
        logic [7:0] r[$];
        cmd(8'h05, 2, r);
        chk("mode readback", exp, r[0]);
        chk("mode repeat", exp, r[1]);
    endtask
    task automatic write_mode_cmd(input logic [7:0] v);
        logic [7:0] r[$];
        logic [7:0] q[$];
        q = {8'h01, v};
        u_ssr_master_model.frame(q, 0, r);
        mode = v[7:6];
    endtask
    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        $display("ERROR watchdog expected done seen timeout");
        give_verdict;
    end
    initial begin
        logic [7:0] r[$];
        int n0;
        rst = 1'b1;
        mem_hold = 1'b0;
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk);
        #1;
        read_mode_cmd(8'h40);
        wr(32'hFFFE, 4, 1'b1);
        rd(32'hFFFE, 4);
        write_mode_cmd(8'h00);
        wr(32'hFFFF, 2, 1'b1);
        rd(32'hFFFF, 1);
        write_mode_cmd(8'h40);
        rd(32'hFFFE, 4);
        write_mode_cmd(8'h80);
        wr(32'h1230, 34, 1'b1);
        rd(32'h1230, 32);
        write_mode_cmd(8'hC0);
        read_mode_cmd(8'hC0);
        n0 = oe_cnt;
        cmd(8'h03, 3, r);
        chk("drive in reserved mode", 8'h00, {7'h00, oe_cnt != n0});
        n0 = oe_cnt;
        cmd(8'h77, 3, r);
        chk("drive after unknown opcode", 8'h00, {7'h00, oe_cnt != n0});
        write_mode_cmd(8'h40);
        mem_hold = 1'b1;
        wr(32'h4000, 7, 1'b0);
        chk("overrun flag", 8'h01, {7'h00, wr_overrun});
        chk("buffer ready", 8'h00, {7'h00, wr_buf_ready});
        mem_hold = 1'b0;
        read_mode_cmd(8'h40);
        chk("overrun flag", 8'h00, {7'h00, wr_overrun});
        cmd(8'h3B, 2, r);
        chk("dual flag", 8'h01, {7'h00, dual_mode});
        wr(32'h0200, 3, 1'b1);
        rd(32'h0200, 3);
        read_mode_cmd(8'h40);
        cmd(8'hFF, 1, r);
        chk("dual flag", 8'h00, {7'h00, dual_mode});
        rd(32'hFFFE, 2);
        give_verdict;
    end
endmodule // ssr_spi_slave_tb_top
